// *** verilog/aecr_map.vh ***
// register offsets, field positions and reset values of the alert-enable and command bank
// assumes: byte-wide register port, write address even, read address = write address + 1
`ifndef AECR_MAP_VH
`define AECR_MAP_VH
// ==========================================
// write addresses (read address is one above)
`define AECR_BUF_ALERT_EN_ADDR 8'h2A
`define AECR_WD_ALERT_EN_ADDR 8'h2C
`define AECR_PIN_ALERT_EN_ADDR 8'h2E
`define AECR_CLR_TX_ADDR 8'h40
`define AECR_CLR_RX_ADDR 8'h42
`define AECR_CLR_LOCKSTEP_ADDR 8'h44
`define AECR_CLR_SEED_ADDR 8'h48
`define AECR_SW_RESET_ADDR 8'h4A
`define AECR_SLEEP_EN_ADDR 8'h4C
// ==========================================
// writable bit masks
`define AECR_BUF_ALERT_MASK 8'h88
`define AECR_WD_ALERT_MASK 8'h1F
`define AECR_PIN_ALERT_MASK 8'h0F
`define AECR_CMD_BIT 0
// ==========================================
// field positions inside the enable registers
`define AECR_BUF_FULL_BIT 7
`define AECR_LOCKSTEP_FULL_BIT 3
`define AECR_WD_TIMEOUT_BIT 4
`define AECR_WD_WINDOW_OPEN_BIT 3
`define AECR_WD_SEQUENCE_BIT 2
`define AECR_WD_REJECT_BIT 1
`define AECR_WD_EXPIRED_BIT 0
`define AECR_PIN4_BIT 3
`define AECR_PIN3_BIT 2
`define AECR_PIN2_BIT 1
`define AECR_PIN1_BIT 0
// ==========================================
// reset values
`define AECR_ALERT_EN_RESET 8'h00
`define AECR_CMD_RESET 8'h00
`endif

// *** verilog/aecr_cmd_gate.v ***
// command gate: decides whether a clear command is taken or refused
// assumes: busy and mode levels already synchronous to CLK
`timescale 1ns/1ps
`default_nettype none
module aecr_cmd_gate (
   input wire write_strobe, // one-cycle write of a command register
   input wire sleep_active, // sleep in progress
   input wire verify_active, // config verify in progress
   input wire load_active, // config load in progress
   input wire safe_mon_active, // safe monitoring mode
   output wire accept, // command takes effect
   output wire refuse // command refused, raises port error
);
   // ==========================================
   // any running process or safe mode blocks the command
   wire blocked;
   assign blocked = sleep_active | verify_active | load_active | safe_mon_active; // [R3]
   assign accept = write_strobe & ~blocked;
   assign refuse = write_strobe & blocked; // [R3]
endmodule // aecr_cmd_gate
`default_nettype wire

// *** verilog/aecr_alert_mask.v ***
// alert mask: gates status conditions by their enable bits
// assumes: status bits are levels on the CLK domain
`timescale 1ns/1ps
`default_nettype none
module aecr_alert_mask #(
   parameter WIDTH = 8 // number of status conditions
) (
   input wire [WIDTH-1:0] status, // raw status conditions
   input wire [WIDTH-1:0] enable, // per-condition enable
   output wire alert // any enabled condition present
);
   // ==========================================
   // masked conditions still stay in status; only the pin is gated
   assign alert = |(status & enable); // [R8]
endmodule // aecr_alert_mask
`default_nettype wire

// *** verilog/aecr_bank.v ***
// alert-enable and one-shot command registers of the bridge's host register bank
// assumes: a serial port front end presents one-cycle byte write/read strobes on CLK;
// buffers, watchdog, sleep logic and the alert pin driver live outside this block.
// Contract
// R1: clear-transmit command empties transmit buffer
// R2: clear-transmit also zeroes transmit and load counts
// R3: clear commands refused while busy; refusal flags error
// R4: clear-receive command empties receive buffer
// R5: seed clear ignored if queue nonzero; flags error
// R6: software reset acts like power-on reset
// R7: bit 0 one starts reset; pulse only
// R8: enable bits gate status onto alert output
// ==========================================
// register map, write address / read address
// buffer_alert_enable 0x2A / 0x2B
//    bit 7 alert_buffer_full_alert_en
//    bit 3 lockstep_full_alert_en
// watchdog_alert_enable 0x2C / 0x2D
//    bit 4 watchdog_timeout_alert_en
//    bit 3 watchdog_window_open_alert_en
//    bit 2 watchdog_sequence_error_alert_en
//    bit 1 watchdog_reject_alert_en
//    bit 0 watchdog_expired_alert_en
// pin_fault_alert_enable 0x2E / 0x2F
//    bit 3 pin4_fault_alert_en
//    bit 2 pin3_fault_alert_en
//    bit 1 pin2_fault_alert_en
//    bit 0 pin1_fault_alert_en
// clear_transmit_buffer_cmd 0x40, write only, any data
// clear_receive_buffer_cmd 0x42, write only, any data
// clear_lockstep_machine_cmd 0x44, write only, any data
// clear_alive_seed_cmd 0x48, write only, any data
// software_reset_cmd 0x4A, bit 0, pulse, reads back 0
// sleep_enable_cmd 0x4C, bit 0, level, also cleared on sleep exit
// ==========================================
// limitations
// reserved enable bits ignore writes and read 0, so 0xFF is safe
// a refusal is judged on the busy levels of the write cycle only;
//    a process starting in that same cycle already blocks the command
// the software reset pulse only asks for a reset; the reset
//    generator outside must pull RESETN low in turn
// queue, seed and buffer contents live outside; this bank only pulses
// the clear pulses carry no data, so the far side must act on the
//    single cycle in which they stand
`timescale 1ns/1ps
`default_nettype none
`include "aecr_map.vh"
module aecr_bank (
   input wire CLK, // core clock, 40 MHz
   input wire RESETN, // synchronous power-on reset, active low
   input wire WR_EN, // one-cycle register write strobe
   input wire RD_EN, // one-cycle register read strobe
   input wire [7:0] ADDR, // register address (write even, read odd)
   input wire [7:0] WDATA, // write data
   output reg [7:0] RDATA, // read data, valid cycle after RD_EN
   input wire SLEEP_ACTIVE, // sleep process running
   input wire VERIFY_ACTIVE, // config verify running
   input wire LOAD_ACTIVE, // config load running
   input wire SAFE_MON_ACTIVE, // safe monitoring mode
   input wire SLEEP_EXIT, // sleep exit seen, clears sleep enable
   input wire ALIVE_QUEUE_NONZERO, // alive-counter queue count not zero
   input wire [7:0] BUF_STATUS, // buffer status conditions
   input wire [7:0] WD_STATUS, // watchdog status conditions
   input wire [7:0] PIN_STATUS, // pin fault status conditions
   output reg CLEAR_TX_BUFFER, // pulse: empty transmit buffer
   output reg CLEAR_TX_COUNTS, // pulse: zero transmit and load queue counts
   output reg CLEAR_RX_BUFFER, // pulse: empty receive buffer
   output reg CLEAR_LOCKSTEP, // pulse: reset lock-step machine
   output reg CLEAR_ALIVE_SEED, // pulse: zero alive seed
   output reg ALIVE_ERROR_SET, // pulse: set alive error flag
   output reg SERIAL_PORT_ERROR_SET, // pulse: set serial port error flag
   output reg SOFTWARE_RESET, // pulse: device-wide power-on reset
   output reg SLEEP_ENABLE, // sleep request level
   output wire BUF_ALERT, // buffer alert request
   output wire WD_ALERT, // watchdog alert request
   output wire PIN_ALERT // pin fault alert request
);
   // ==========================================
   // enable registers
   reg [7:0] buffer_alert_enable;
   reg [7:0] watchdog_alert_enable;
   reg [7:0] pin_fault_alert_enable;

   // ==========================================
   // address match, shared by every write decode
   function addr_hit(input [7:0] bus_addr, input [7:0] target);
      addr_hit = (bus_addr == target);
   endfunction

   // read address sits one above the write address; eight bits on
   // purpose, no register of this bank lives near the top of the map
   function [7:0] read_addr(input [7:0] wr_addr);
      read_addr = wr_addr + 8'h01;
   endfunction

   // ==========================================
   // write decode
   wire wr_buf_en;
   wire wr_wd_en;
   wire wr_pin_en;
   wire wr_clr_tx;
   wire wr_clr_rx;
   wire wr_clr_ls;
   wire wr_clr_seed;
   wire wr_swrst;
   wire wr_sleep;
   wire cmd_one;
   assign cmd_one = WDATA[`AECR_CMD_BIT];
   assign wr_buf_en = WR_EN & addr_hit(ADDR, `AECR_BUF_ALERT_EN_ADDR);
   assign wr_wd_en = WR_EN & addr_hit(ADDR, `AECR_WD_ALERT_EN_ADDR);
   assign wr_pin_en = WR_EN & addr_hit(ADDR, `AECR_PIN_ALERT_EN_ADDR);
   assign wr_clr_tx = WR_EN & addr_hit(ADDR, `AECR_CLR_TX_ADDR);
   assign wr_clr_rx = WR_EN & addr_hit(ADDR, `AECR_CLR_RX_ADDR);
   assign wr_clr_ls = WR_EN & addr_hit(ADDR, `AECR_CLR_LOCKSTEP_ADDR);
   assign wr_clr_seed = WR_EN & addr_hit(ADDR, `AECR_CLR_SEED_ADDR);
   assign wr_swrst = WR_EN & addr_hit(ADDR, `AECR_SW_RESET_ADDR);
   assign wr_sleep = WR_EN & addr_hit(ADDR, `AECR_SLEEP_EN_ADDR);

   // ==========================================
   // gating of commands; sleep itself does not block the sleep bit
   // (clearing it is how the host leaves sleep)
   wire any_clear;
   wire clr_accept;
   wire clr_refuse;
   wire sleep_blocked;
   assign any_clear = wr_clr_tx | wr_clr_rx | wr_clr_ls | wr_clr_seed;
   aecr_cmd_gate u_gate (
      .write_strobe(any_clear),
      .sleep_active(SLEEP_ACTIVE),
      .verify_active(VERIFY_ACTIVE),
      .load_active(LOAD_ACTIVE),
      .safe_mon_active(SAFE_MON_ACTIVE),
      .accept(clr_accept),
      .refuse(clr_refuse)
   );
   assign sleep_blocked = VERIFY_ACTIVE | LOAD_ACTIVE | SAFE_MON_ACTIVE;

   // ==========================================
   // enable registers, reserved bits held at zero
   always @(posedge CLK) begin
      if (!RESETN) begin
         buffer_alert_enable <= `AECR_ALERT_EN_RESET;
         watchdog_alert_enable <= `AECR_ALERT_EN_RESET;
         pin_fault_alert_enable <= `AECR_ALERT_EN_RESET;
      end else begin
         if (wr_buf_en) begin
            buffer_alert_enable <= WDATA & `AECR_BUF_ALERT_MASK;
         end
         if (wr_wd_en) begin
            watchdog_alert_enable <= WDATA & `AECR_WD_ALERT_MASK;
         end
         if (wr_pin_en) begin
            pin_fault_alert_enable <= WDATA & `AECR_PIN_ALERT_MASK;
         end
      end
   end

   // ==========================================
   // next values of the command pulses, kept apart from the flops
   // so each accept or refuse decision reads in one place
   reg next_clear_tx;
   reg next_clear_rx;
   reg next_clear_ls;
   reg next_clear_seed;
   reg next_alive_err;
   reg next_port_err;
   reg next_sw_reset;
   always @* begin
      next_clear_tx = clr_accept & wr_clr_tx; // [R1] [R2]
      next_clear_rx = clr_accept & wr_clr_rx; // [R4]
      next_clear_ls = clr_accept & wr_clr_ls;
      // a queue still in use turns the seed clear into an error report
      next_clear_seed = clr_accept & wr_clr_seed & ~ALIVE_QUEUE_NONZERO; // [R5]
      next_alive_err = clr_accept & wr_clr_seed & ALIVE_QUEUE_NONZERO; // [R5]
      // a refused sleep write reports through the same flag
      next_port_err = clr_refuse | (wr_sleep & sleep_blocked); // [R3]
      // writing 0 does nothing
      next_sw_reset = wr_swrst & cmd_one; // [R6] [R7]
   end

   // ==========================================
   // one-shot command pulses, each high for exactly one cycle
   always @(posedge CLK) begin
      if (!RESETN) begin
         CLEAR_TX_BUFFER <= 1'b0;
         CLEAR_TX_COUNTS <= 1'b0;
         CLEAR_RX_BUFFER <= 1'b0;
         CLEAR_LOCKSTEP <= 1'b0;
         CLEAR_ALIVE_SEED <= 1'b0;
         ALIVE_ERROR_SET <= 1'b0;
         SERIAL_PORT_ERROR_SET <= 1'b0;
         SOFTWARE_RESET <= 1'b0;
      end else begin
         CLEAR_TX_BUFFER <= next_clear_tx; // [R1]
         CLEAR_TX_COUNTS <= next_clear_tx; // [R2]
         CLEAR_RX_BUFFER <= next_clear_rx; // [R4]
         CLEAR_LOCKSTEP <= next_clear_ls;
         CLEAR_ALIVE_SEED <= next_clear_seed; // [R5]
         ALIVE_ERROR_SET <= next_alive_err; // [R5]
         SERIAL_PORT_ERROR_SET <= next_port_err; // [R3]
         // the bit never holds, so it reads back 0
         SOFTWARE_RESET <= next_sw_reset; // [R6] [R7]
      end
   end

   // ==========================================
   // sleep enable: set by host, cleared by host or on sleep exit
   // a host write and an exit in one cycle: the write wins, the host asked last
   always @(posedge CLK) begin
      if (!RESETN) begin
         SLEEP_ENABLE <= 1'b0;
      end else if (wr_sleep & ~sleep_blocked) begin
         SLEEP_ENABLE <= cmd_one;
      end else if (SLEEP_EXIT) begin
         SLEEP_ENABLE <= 1'b0;
      end
   end

   // ==========================================
   // read path; command-only registers read zero
   // reads have no side effect, so the host may poll freely
   reg [7:0] next_rdata;
   always @* begin
      next_rdata = 8'h00;
      case (ADDR)
         read_addr(`AECR_BUF_ALERT_EN_ADDR): next_rdata = buffer_alert_enable;
         read_addr(`AECR_WD_ALERT_EN_ADDR): next_rdata = watchdog_alert_enable;
         read_addr(`AECR_PIN_ALERT_EN_ADDR): next_rdata = pin_fault_alert_enable;
         read_addr(`AECR_SLEEP_EN_ADDR): next_rdata = {7'h00, SLEEP_ENABLE};
         default: next_rdata = 8'h00;
      endcase
   end

   always @(posedge CLK) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
      end else if (RD_EN) begin
         RDATA <= next_rdata;
      end
   end

   // ==========================================
   // named enable fields; the masks are fed from these alone, so a
   // reserved bit could never reach an alert even if a flop held one
   wire alert_buffer_full_alert_en;
   wire lockstep_full_alert_en;
   wire watchdog_timeout_alert_en;
   wire watchdog_window_open_alert_en;
   wire watchdog_sequence_error_alert_en;
   wire watchdog_reject_alert_en;
   wire watchdog_expired_alert_en;
   wire pin1_fault_alert_en;
   wire pin2_fault_alert_en;
   wire pin3_fault_alert_en;
   wire pin4_fault_alert_en;
   assign alert_buffer_full_alert_en = buffer_alert_enable[`AECR_BUF_FULL_BIT];
   assign lockstep_full_alert_en = buffer_alert_enable[`AECR_LOCKSTEP_FULL_BIT];
   assign watchdog_timeout_alert_en = watchdog_alert_enable[`AECR_WD_TIMEOUT_BIT];
   assign watchdog_window_open_alert_en = watchdog_alert_enable[`AECR_WD_WINDOW_OPEN_BIT];
   assign watchdog_sequence_error_alert_en = watchdog_alert_enable[`AECR_WD_SEQUENCE_BIT];
   assign watchdog_reject_alert_en = watchdog_alert_enable[`AECR_WD_REJECT_BIT];
   assign watchdog_expired_alert_en = watchdog_alert_enable[`AECR_WD_EXPIRED_BIT];
   assign pin1_fault_alert_en = pin_fault_alert_enable[`AECR_PIN1_BIT];
   assign pin2_fault_alert_en = pin_fault_alert_enable[`AECR_PIN2_BIT];
   assign pin3_fault_alert_en = pin_fault_alert_enable[`AECR_PIN3_BIT];
   assign pin4_fault_alert_en = pin_fault_alert_enable[`AECR_PIN4_BIT];

   // ==========================================
   // enable vectors, each field at the bit of its status condition
   reg [7:0] buf_enable_bits;
   reg [7:0] wd_enable_bits;
   reg [7:0] pin_enable_bits;
   always @* begin
      buf_enable_bits = 8'h00;
      wd_enable_bits = 8'h00;
      pin_enable_bits = 8'h00;
      buf_enable_bits[`AECR_BUF_FULL_BIT] = alert_buffer_full_alert_en;
      buf_enable_bits[`AECR_LOCKSTEP_FULL_BIT] = lockstep_full_alert_en;
      wd_enable_bits[`AECR_WD_TIMEOUT_BIT] = watchdog_timeout_alert_en;
      wd_enable_bits[`AECR_WD_WINDOW_OPEN_BIT] = watchdog_window_open_alert_en;
      wd_enable_bits[`AECR_WD_SEQUENCE_BIT] = watchdog_sequence_error_alert_en;
      wd_enable_bits[`AECR_WD_REJECT_BIT] = watchdog_reject_alert_en;
      wd_enable_bits[`AECR_WD_EXPIRED_BIT] = watchdog_expired_alert_en;
      pin_enable_bits[`AECR_PIN1_BIT] = pin1_fault_alert_en;
      pin_enable_bits[`AECR_PIN2_BIT] = pin2_fault_alert_en;
      pin_enable_bits[`AECR_PIN3_BIT] = pin3_fault_alert_en;
      pin_enable_bits[`AECR_PIN4_BIT] = pin4_fault_alert_en;
   end

   // ==========================================
   // alert gating per group
   aecr_alert_mask #(.WIDTH(8)) u_buf_mask (
      .status(BUF_STATUS),
      .enable(buf_enable_bits),
      .alert(BUF_ALERT)
   );
   aecr_alert_mask #(.WIDTH(8)) u_wd_mask (
      .status(WD_STATUS),
      .enable(wd_enable_bits),
      .alert(WD_ALERT)
   );
   aecr_alert_mask #(.WIDTH(8)) u_pin_mask (
      .status(PIN_STATUS),
      .enable(pin_enable_bits),
      .alert(PIN_ALERT)
   );
endmodule // aecr_bank
`default_nettype wire

// *** verification/aecr_bank_chk.sv ***
// checker: command pulse timing, refusals and buffer alert masking at the bank ports
// assumes: bound into aecr_bank, one CLK domain, reset synchronous and active low
`timescale 1ns/1ps
`default_nettype none
module aecr_bank_chk (
   input wire logic CLK, // core clock
   input wire logic RESETN, // reset, low
   input wire logic WR_EN, // write strobe
   input wire logic [7:0] ADDR, // address
   input wire logic [7:0] WDATA, // write data
   input wire logic SLEEP_ACTIVE, // busy level
   input wire logic VERIFY_ACTIVE, // busy level
   input wire logic LOAD_ACTIVE, // busy level
   input wire logic SAFE_MON_ACTIVE, // busy level
   input wire logic ALIVE_QUEUE_NONZERO, // queue level
   input wire logic [7:0] BUF_STATUS, // buffer status
   input wire logic CLEAR_TX_BUFFER, // pulse
   input wire logic CLEAR_TX_COUNTS, // pulse
   input wire logic CLEAR_RX_BUFFER, // pulse
   input wire logic CLEAR_ALIVE_SEED, // pulse
   input wire logic ALIVE_ERROR_SET, // pulse
   input wire logic SERIAL_PORT_ERROR_SET, // pulse
   input wire logic SOFTWARE_RESET, // pulse
   input wire logic BUF_ALERT // alert request
);
   // ==========================================
   // shadow of the buffer enable; only bits 7 and 3 are kept
   logic [7:0] en_shadow;
   wire busy = SLEEP_ACTIVE | VERIFY_ACTIVE | LOAD_ACTIVE | SAFE_MON_ACTIVE;
   always_ff @(posedge CLK) begin
      if (!RESETN) en_shadow <= 8'h00;
      else if (WR_EN && ADDR == 8'h2A) en_shadow <= WDATA & 8'h88;
   end
   // ==========================================
   // properties; a clear write counts only while nothing is busy
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence s_ok(logic [7:0] a); WR_EN && !busy && ADDR == a; endsequence
   property p_tx; s_ok(8'h40) |=> CLEAR_TX_BUFFER && CLEAR_TX_COUNTS; endproperty
   a_tx: assert property (p_tx) else $error("transmit clear pulse missing");
   property p_rx; s_ok(8'h42) |=> CLEAR_RX_BUFFER; endproperty
   a_rx: assert property (p_rx) else $error("receive clear pulse missing");
   property p_ref; WR_EN && busy && ADDR inside {8'h40, 8'h42, 8'h44, 8'h48}
      |=> SERIAL_PORT_ERROR_SET && !CLEAR_TX_BUFFER && !CLEAR_RX_BUFFER && !CLEAR_ALIVE_SEED; endproperty
   a_ref: assert property (p_ref) else $error("busy clear not refused");
   property p_err_src; SERIAL_PORT_ERROR_SET |-> $past(WR_EN) && $past(busy); endproperty
   a_err_src: assert property (p_err_src) else $error("port error without refused write");
   property p_seed; s_ok(8'h48) ##0 !ALIVE_QUEUE_NONZERO |=> CLEAR_ALIVE_SEED && !ALIVE_ERROR_SET; endproperty
   a_seed: assert property (p_seed) else $error("seed clear wrong");
   property p_seed_err; s_ok(8'h48) ##0 ALIVE_QUEUE_NONZERO |=> ALIVE_ERROR_SET && !CLEAR_ALIVE_SEED; endproperty
   a_seed_err: assert property (p_seed_err) else $error("seed clear not ignored");
   property p_swr; WR_EN && ADDR == 8'h4A && WDATA[0] |=> SOFTWARE_RESET; endproperty
   a_swr: assert property (p_swr) else $error("software reset pulse missing");
   property p_swr_src; SOFTWARE_RESET |-> $past(WR_EN) && $past(ADDR) == 8'h4A && $past(WDATA[0]); endproperty
   a_swr_src: assert property (p_swr_src) else $error("software reset without a one");
   property p_alert; BUF_ALERT == |(BUF_STATUS & en_shadow); endproperty
   a_alert: assert property (p_alert) else $error("buffer alert not masked by enable");
endmodule // aecr_bank_chk
bind aecr_bank aecr_bank_chk u_aecr_bank_chk (.CLK(CLK), .RESETN(RESETN), .WR_EN(WR_EN), .ADDR(ADDR),
   .WDATA(WDATA), .SLEEP_ACTIVE(SLEEP_ACTIVE), .VERIFY_ACTIVE(VERIFY_ACTIVE), .LOAD_ACTIVE(LOAD_ACTIVE),
   .SAFE_MON_ACTIVE(SAFE_MON_ACTIVE), .ALIVE_QUEUE_NONZERO(ALIVE_QUEUE_NONZERO), .BUF_STATUS(BUF_STATUS),
   .CLEAR_TX_BUFFER(CLEAR_TX_BUFFER), .CLEAR_TX_COUNTS(CLEAR_TX_COUNTS), .CLEAR_RX_BUFFER(CLEAR_RX_BUFFER),
   .CLEAR_ALIVE_SEED(CLEAR_ALIVE_SEED), .ALIVE_ERROR_SET(ALIVE_ERROR_SET),
   .SERIAL_PORT_ERROR_SET(SERIAL_PORT_ERROR_SET), .SOFTWARE_RESET(SOFTWARE_RESET), .BUF_ALERT(BUF_ALERT));
`default_nettype wire

// *** verification/aecr_host_model.sv ***
// host model: byte write and read strobes towards the bank
// assumes: request taken at a rising edge, read data settled just after that edge
`timescale 1ns/1ps
`default_nettype none
module aecr_host_model (
   input wire logic CLK, // core clock
   input wire logic [7:0] RDATA, // read data
   output logic WR_EN, // write strobe
   output logic RD_EN, // read strobe
   output logic [7:0] ADDR, // address
   output logic [7:0] WDATA // write data
);
   // ==========================================
   // idle bus; released lines show the inverse so stale values never pass
   initial begin
      WR_EN = 1'b0;
      RD_EN = 1'b0;
      ADDR = 8'h00;
      WDATA = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      WR_EN <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR_EN <= 1'b0;
      ADDR <= ~a;
      WDATA <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLK);
      RD_EN <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD_EN <= 1'b0;
      ADDR <= ~a;
      #1 d = RDATA;
   endtask
endmodule // aecr_host_model
`default_nettype wire

// *** verification/test_aecr_bank.sv ***
// testbench: enable registers, alert masking, clear commands, refusals, software reset, sleep
// assumes: host model drives the register strobes; busy, queue and status levels driven here
`timescale 1ns/1ps
`default_nettype none
module test_aecr_bank;
   logic clk, resetn, sleep_exit, q_nonzero;
   logic [3:0] busy_in;
   logic [7:0] got;
   logic [7:0] st [0:2];
   logic [7:0] ea [0:2] = '{8'h2A, 8'h2C, 8'h2E};
   logic [7:0] em [0:2] = '{8'h88, 8'h1F, 8'h0F};
   logic [7:0] ca [0:3] = '{8'h40, 8'h42, 8'h44, 8'h48};
   wire logic wr_en, rd_en, sleep_en;
   wire logic [2:0] alrt;
   wire logic [7:0] addr, wdata, rdata, pv;
   int err_total = 0;
   int n_compared = 0;
   aecr_host_model u_aecr_host_model (.CLK(clk), .RDATA(rdata), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
      .WDATA(wdata));
   aecr_bank u_aecr_bank (.CLK(clk), .RESETN(resetn), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
      .WDATA(wdata), .RDATA(rdata), .SLEEP_ACTIVE(busy_in[0]), .VERIFY_ACTIVE(busy_in[1]),
      .LOAD_ACTIVE(busy_in[2]), .SAFE_MON_ACTIVE(busy_in[3]), .SLEEP_EXIT(sleep_exit),
      .ALIVE_QUEUE_NONZERO(q_nonzero), .BUF_STATUS(st[0]), .WD_STATUS(st[1]), .PIN_STATUS(st[2]),
      .CLEAR_TX_BUFFER(pv[7]), .CLEAR_TX_COUNTS(pv[6]), .CLEAR_RX_BUFFER(pv[5]), .CLEAR_LOCKSTEP(pv[4]),
      .CLEAR_ALIVE_SEED(pv[3]), .ALIVE_ERROR_SET(pv[2]), .SERIAL_PORT_ERROR_SET(pv[1]),
      .SOFTWARE_RESET(pv[0]), .SLEEP_ENABLE(sleep_en), .BUF_ALERT(alrt[0]), .WD_ALERT(alrt[1]),
      .PIN_ALERT(alrt[2]));
   // ==========================================
   // compare, command and closing tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      u_aecr_host_model.rd(a, got);
      chk("read data", exp, got);
   endtask
   // pulses show in the cycle after the write and last one cycle only
   task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      u_aecr_host_model.wr(a, d);
      #1 chk("pulses", exp, pv);
      @(posedge clk);
      #1 chk("pulses after", 8'h00, pv);
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   // ==========================================
   // main sequence
   initial begin
      resetn = 1'b0;
      busy_in = 4'h0;
      sleep_exit = 1'b0;
      q_nonzero = 1'b0;
      st = '{8'h00, 8'h00, 8'h00};
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      // reset value, writable bits, masking with status present
      for (int i = 0; i < 3; i++) begin
         rdchk(ea[i] + 8'h01, 8'h00);
         u_aecr_host_model.wr(ea[i], 8'hFF);
         rdchk(ea[i] + 8'h01, em[i]);
         @(posedge clk);
         st[i] <= ~em[i];
         #1 chk("alert idle bits", 8'h00, {7'h00, alrt[i]});
         @(posedge clk);
         st[i] <= em[i];
         #1 chk("alert enabled", 8'h01, {7'h00, alrt[i]});
         u_aecr_host_model.wr(ea[i], 8'h00);
         #1 chk("alert masked", 8'h00, {7'h00, alrt[i]});
      end
      u_aecr_host_model.wr(8'h30, 8'hFF);
      rdchk(8'h31, 8'h00);
      $display("enable registers done");
      cmd(8'h40, 8'h00, 8'hC0);
      cmd(8'h42, 8'h5A, 8'h20);
      cmd(8'h44, 8'h01, 8'h10);
      cmd(8'h48, 8'h01, 8'h08);
      @(posedge clk) q_nonzero <= 1'b1;
      cmd(8'h48, 8'h01, 8'h04);
      cmd(8'h4A, 8'hFE, 8'h00);
      cmd(8'h4A, 8'h01, 8'h01);
      rdchk(8'h4B, 8'h00);
      $display("commands done");
      // every busy source against every clear command
      for (int b = 0; b < 4; b++) begin
         @(posedge clk) busy_in <= 4'h1 << b;
         foreach (ca[c]) cmd(ca[c], 8'hFF, 8'h02);
      end
      $display("refusals done");
      cmd(8'h4C, 8'h01, 8'h02);
      rdchk(8'h4D, 8'h00);
      chk("sleep enable", 8'h00, {7'h00, sleep_en});
      @(posedge clk) busy_in <= 4'h1;
      cmd(8'h4C, 8'h01, 8'h00);
      rdchk(8'h4D, 8'h01);
      chk("sleep enable", 8'h01, {7'h00, sleep_en});
      @(posedge clk) sleep_exit <= 1'b1;
      @(posedge clk) sleep_exit <= 1'b0;
      rdchk(8'h4D, 8'h00);
      chk("sleep enable", 8'h00, {7'h00, sleep_en});
      $display("sleep done");
      wrap_up();
   end
endmodule // test_aecr_bank
`default_nettype wire
